// ===== rtl/mhb_consts.vh
// Purpose: constants for the host bus master
// Assumes: mclk at 100 MHz
// Notes:   bus timing counted in half periods of the bus clock
`ifndef MHB_CONSTS_VH
`define MHB_CONSTS_VH

`define MHB_MCLK_PERIOD_NS 10
`define MHB_BUS_HALF_NS    40
`define MHB_BUS_HALF_CYC   (`MHB_BUS_HALF_NS / `MHB_MCLK_PERIOD_NS)

// phase widths in bus half periods
`define MHB_HALF_NORM      4'h2
`define MHB_HALF_ADDR      4'h2
`define MHB_HALF_ALE_MAX   4'h4
`define MHB_HALF_RDCS_MAX  4'h6
`define MHB_HALF_WR_MAX    4'hC
`define MHB_HALF_RD_MAX    4'hA

// command codes
`define MHB_OP_READ        3'h0
`define MHB_OP_READ_EXT    3'h1
`define MHB_OP_WRITE       3'h2
`define MHB_OP_WRITE_EXT   3'h3
`define MHB_OP_AUX_SET     3'h4
`define MHB_OP_AUX_READ    3'h5
`define MHB_OP_WAIT_HIGH   3'h6
`define MHB_OP_WAIT_LOW    3'h7

`endif

// ===== rtl/mhb_clk_div.v
// Purpose: bus clock divider with half-period tick
// Assumes: half_cyc of at least 1
// Notes:   clk_out toggles on every tick
`timescale 1ns/1ps
module mhb_clk_div #(
  parameter HALF_CYC = 4
) (
  // clock and reset
  input  wire mclk,
  input  wire rst_n,
  // divided outputs
  output reg  clk_out,
  output reg  half_tick
);

  reg [15:0] cnt_reg;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg   <= 16'h0000;
      clk_out   <= 1'b0;
      half_tick <= 1'b0;
    end else if (cnt_reg == HALF_CYC[15:0] - 16'h0001) begin
      cnt_reg   <= 16'h0000;
      clk_out   <= ~clk_out;
      half_tick <= 1'b1;
    end else begin
      cnt_reg   <= cnt_reg + 16'h0001;
      half_tick <= 1'b0;
    end
  end

endmodule

// ===== rtl/mhb_bus_master.v
// Purpose: multiplexed address/data host bus master driven by a command port
// Assumes: commands come from logic on mclk; pins are asynchronous
// Notes:   phases step on half periods of the divided bus clock
`timescale 1ns/1ps
`include "mhb_consts.vh"

// How it works
// [R1] The low eight bus lines, bits 6 and 7 included, carry address then data, direction switched per phase.
// [R2] The first auxiliary pin is set, cleared and read by the host's pin commands.
// [R3] The second auxiliary pin has commands that stall command processing until it is seen high or low.
// [R4] Tied to a peripheral interrupt, that pin is waited on and the queued read then runs and answers the host.
// [R5] The host keeps the second auxiliary pin an input while using the wait commands on it.
// [R6] A low wait-extend input stretches the affected strobe phases while it is sampled low.
// [R7] The bus sequencing clock is put out on the clock monitor pin.
// [R8] Eight output-only upper address lines extend the address above the low byte.
// [R9] Chip select pulses low during every read and write cycle.
// [R10] A positive address latch pulse lets the peripheral capture the low address byte.
// [R11] Read and write strobes are active low and write data is stable before the fall and after the rise.
// [R12] Read, write, extended read and extended write exist and only the extended ones change the upper address.
// [R13] The host enters this mode with mode value 8 and value 0 restores the reset configuration.
// [R14] The write strobe has its normal width and stretches up to 6 clocks while wait-extend is low.
// [R15] The address latch pulse widens to 2 clocks while wait-extend is low.
// [R16] The address phase and latch pulse complete before the lines carry data.
// [R17] Commands run strictly in order, one bus cycle finishing before the next starts.
module mhb_bus_master #(
  parameter HALF_CYC = `MHB_BUS_HALF_CYC
) (
  // clock and reset
  input  wire        mclk,
  input  wire        reset_n,
  // host command port
  input  wire        cmd_valid,
  output reg         cmd_ready_reg,
  input  wire [2:0]  cmd_op,
  input  wire [15:0] cmd_addr,
  input  wire [7:0]  cmd_data,
  output reg         rsp_valid_reg,
  output reg  [7:0]  rsp_data_reg,
  // multiplexed bus
  input  wire [7:0]  ad_in,
  output reg  [7:0]  ad_out_reg,
  output reg         ad_oe_reg,
  output reg  [7:0]  addr_hi_reg,
  output reg         cs_n_reg,
  output reg         ale_reg,
  output reg         rd_n_reg,
  output reg         wr_n_reg,
  input  wire        wait_extend_in,
  // auxiliary pins
  input  wire        aux_pin_first_in,
  output reg         aux_pin_first_out_reg,
  output reg         aux_pin_first_oe_reg,
  input  wire        aux_irq_pin_in,
  output reg         aux_irq_pin_out_reg,
  output reg         aux_irq_pin_oe_reg,
  // clock monitor
  output wire        clock_monitor_out
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ALE  = 3'h2;
  localparam ST_DSET = 3'h3;
  localparam ST_STRB = 3'h4;
  localparam ST_HOLD = 3'h5;
  localparam ST_WAIT = 3'h6;

  reg [1:0] rst_sync_reg;
  wire      rst_n;
  reg [1:0] wait_sync_reg;
  reg [1:0] aux0_sync_reg;
  reg [1:0] aux1_sync_reg;
  reg [7:0] ad_meta_reg;
  reg [7:0] ad_sync_reg;
  reg [2:0] state_reg;
  reg [3:0] cnt_reg;
  reg [2:0] op_reg;
  reg [7:0] data_reg;
  wire      half_tick;
  wire      wait_low;
  wire      is_write;
  wire [3:0] cnt_next;

  assign rst_n    = rst_sync_reg[1];
  assign wait_low = ~wait_sync_reg[1];
  assign is_write = op_reg[1];
  assign cnt_next = cnt_reg + 4'h1;

  // phase ends after normal width unless wait-extend holds it up to max
  function phase_done;
    input [3:0] cnt;
    input [3:0] max;
    input       wlow;
    begin
      phase_done = (cnt >= `MHB_HALF_NORM) && !(wlow && (cnt < max));
    end
  endfunction

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_sync_reg <= 2'b11;
      aux0_sync_reg <= 2'b11;
      aux1_sync_reg <= 2'b11;
      ad_meta_reg   <= 8'h00;
      ad_sync_reg   <= 8'h00;
    end else begin
      wait_sync_reg <= {wait_sync_reg[0], wait_extend_in};
      aux0_sync_reg <= {aux0_sync_reg[0], aux_pin_first_in};
      aux1_sync_reg <= {aux1_sync_reg[0], aux_irq_pin_in};
      ad_meta_reg   <= ad_in;
      ad_sync_reg   <= ad_meta_reg;
    end
  end

  mhb_clk_div #(
    .HALF_CYC (HALF_CYC)
  ) u_div (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .clk_out   (clock_monitor_out), // [R7]
    .half_tick (half_tick)
  );

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg             <= ST_IDLE;
      cnt_reg               <= 4'h0;
      op_reg                <= 3'h0;
      data_reg              <= 8'h00;
      cmd_ready_reg         <= 1'b1;
      rsp_valid_reg         <= 1'b0;
      rsp_data_reg          <= 8'h00;
      ad_out_reg            <= 8'h00;
      ad_oe_reg             <= 1'b0;
      addr_hi_reg           <= 8'h00;
      cs_n_reg              <= 1'b1;
      ale_reg               <= 1'b0;
      rd_n_reg              <= 1'b1;
      wr_n_reg              <= 1'b1;
      aux_pin_first_out_reg <= 1'b0;
      aux_pin_first_oe_reg  <= 1'b0;
      aux_irq_pin_out_reg   <= 1'b0;
      aux_irq_pin_oe_reg    <= 1'b0;
    end else begin
      rsp_valid_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (cmd_valid && cmd_ready_reg) begin
            op_reg   <= cmd_op;
            data_reg <= cmd_data;
            cnt_reg  <= 4'h0;
            if (cmd_op == `MHB_OP_AUX_SET) begin
              aux_pin_first_out_reg <= cmd_data[0]; // [R2]
              aux_pin_first_oe_reg  <= cmd_addr[0]; // [R2]
              aux_irq_pin_out_reg   <= cmd_data[1];
              aux_irq_pin_oe_reg    <= cmd_addr[1];
            end else if (cmd_op == `MHB_OP_AUX_READ) begin
              rsp_valid_reg <= 1'b1;
              rsp_data_reg  <= {6'h00, aux1_sync_reg[1], aux0_sync_reg[1]}; // [R2]
            end else if (cmd_op[2]) begin
              cmd_ready_reg <= 1'b0; // [R3]
              state_reg     <= ST_WAIT;
            end else begin
              cmd_ready_reg <= 1'b0; // [R17]
              ad_out_reg    <= cmd_addr[7:0]; // [R1]
              ad_oe_reg     <= 1'b1;
              if (cmd_op[0]) begin
                addr_hi_reg <= cmd_addr[15:8]; // [R8] [R12]
              end
              state_reg <= ST_ADDR;
            end
          end
        end
        ST_WAIT: begin
          if (aux1_sync_reg[1] == ~op_reg[0]) begin
            cmd_ready_reg <= 1'b1; // [R3] [R4]
            state_reg     <= ST_IDLE;
          end
        end
        ST_ADDR: begin
          if (half_tick) begin
            cnt_reg <= cnt_next;
            if (cnt_next >= `MHB_HALF_ADDR) begin
              ale_reg   <= 1'b1; // [R10]
              cnt_reg   <= 4'h0;
              state_reg <= ST_ALE;
            end
          end
        end
        ST_ALE: begin
          if (half_tick) begin
            cnt_reg <= cnt_next;
            if (phase_done(cnt_next, `MHB_HALF_ALE_MAX, wait_low)) begin // [R15] [R6]
              ale_reg   <= 1'b0; // [R16]
              cs_n_reg  <= 1'b0; // [R9]
              cnt_reg   <= 4'h0;
              state_reg <= ST_DSET;
            end
          end
        end
        ST_DSET: begin
          // bus turns one mclk after the latch falls, so the address holds past it
          if (is_write) begin
            ad_out_reg <= data_reg; // [R1] [R16]
          end else begin
            ad_oe_reg <= 1'b0; // [R1]
          end
          if (half_tick) begin
            cnt_reg <= cnt_next;
            if (phase_done(cnt_next, is_write ? `MHB_HALF_NORM : `MHB_HALF_RDCS_MAX, wait_low)) begin // [R6]
              wr_n_reg  <= ~is_write; // [R11]
              rd_n_reg  <= is_write;
              cnt_reg   <= 4'h0;
              state_reg <= ST_STRB;
            end
          end
        end
        ST_STRB: begin
          if (half_tick) begin
            cnt_reg <= cnt_next;
            if (phase_done(cnt_next, is_write ? `MHB_HALF_WR_MAX : `MHB_HALF_RD_MAX, wait_low)) begin // [R14] [R6]
              wr_n_reg  <= 1'b1;
              rd_n_reg  <= 1'b1;
              data_reg  <= is_write ? data_reg : ad_sync_reg;
              state_reg <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          if (half_tick) begin
            cs_n_reg      <= 1'b1; // [R9]
            ad_oe_reg     <= 1'b0; // [R11]
            cmd_ready_reg <= 1'b1; // [R17]
            state_reg     <= ST_IDLE;
            if (!is_write) begin
              rsp_valid_reg <= 1'b1; // [R4]
              rsp_data_reg  <= data_reg;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ===== verification/mhb_monitor.sv
// Purpose: assertion checker for the host bus master ports
// Assumes: bound into mhb_bus_master
// Notes:   strobe widths counted in mclk cycles
`timescale 1ns/1ps
module mhb_monitor #(
  parameter HALF_CYC = 4
) (
  // clock, reset, command port
  input wire        mclk,
  input wire        reset_n,
  input wire        cmd_valid,
  input wire        cmd_ready_reg,
  input wire [2:0]  cmd_op,
  input wire [15:0] cmd_addr,
  input wire        rsp_valid_reg,
  // bus pins
  input wire [7:0]  ad_out_reg,
  input wire        ad_oe_reg,
  input wire [7:0]  addr_hi_reg,
  input wire        cs_n_reg,
  input wire        ale_reg,
  input wire        rd_n_reg,
  input wire        wr_n_reg,
  input wire        clock_monitor_out
);
  localparam int RSP_MAX = 2 * HALF_CYC + 2;
  wire       ext_take = cmd_valid && cmd_ready_reg && cmd_op[0] && !cmd_op[2];
  reg  [7:0] wl_reg;
  reg  [7:0] al_reg;
  reg  [7:0] mh_reg;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wl_reg <= 8'h00;
      al_reg <= 8'h00;
      mh_reg <= 8'h00;
    end else begin
      wl_reg <= wr_n_reg ? 8'h00 : wl_reg + 8'h01;
      al_reg <= ale_reg ? al_reg + 8'h01 : 8'h00;
      mh_reg <= clock_monitor_out ? mh_reg + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  chk_latch_before_data: assert property (ale_reg |-> cs_n_reg && rd_n_reg && wr_n_reg)
    else $error("latch pulse overlaps data phase");
  chk_addr_hold: assert property ($fell(ale_reg) |-> ad_oe_reg && $stable(ad_out_reg))
    else $error("address moved as latch fell");
  chk_strobe_selects: assert property (!rd_n_reg || !wr_n_reg |-> !cs_n_reg && !cmd_ready_reg)
    else $error("strobe without select");
  chk_wr_data_hold: assert property (!wr_n_reg || $rose(wr_n_reg) |-> ad_oe_reg && $stable(ad_out_reg))
    else $error("write data moved around strobe");
  chk_rd_released: assert property (!rd_n_reg |-> !ad_oe_reg)
    else $error("bus driven during read");
  chk_hi_plain_ops: assert property ($changed(addr_hi_reg) |-> $past(ext_take))
    else $error("upper address moved on plain op");
  chk_hi_ext_load: assert property (ext_take |=> addr_hi_reg == $past(cmd_addr[15:8]))
    else $error("upper address not loaded");
  chk_wr_width: assert property ($rose(wr_n_reg) |-> wl_reg >= 2 * HALF_CYC && wl_reg <= 12 * HALF_CYC)
    else $error("write strobe width out of range");
  chk_ale_width: assert property ($fell(ale_reg) |-> al_reg >= 2 * HALF_CYC && al_reg <= 4 * HALF_CYC)
    else $error("latch pulse width out of range");
  chk_rsp_after_rd: assert property ($rose(rd_n_reg) |-> ##[1:RSP_MAX] rsp_valid_reg)
    else $error("no answer after read");
  chk_mon_clock: assert property ($fell(clock_monitor_out) |-> mh_reg == HALF_CYC)
    else $error("monitor clock high time wrong");
  cov_read: cover property ($rose(rsp_valid_reg));
  cov_write: cover property ($fell(wr_n_reg));
  cov_wr_stretch: cover property ($rose(wr_n_reg) && wl_reg == 12 * HALF_CYC);
  cov_ale_stretch: cover property ($fell(ale_reg) && al_reg == 4 * HALF_CYC);
endmodule

bind mhb_bus_master mhb_monitor #(.HALF_CYC(HALF_CYC)) u_mon (.mclk(mclk), .reset_n(reset_n),
  .cmd_valid(cmd_valid), .cmd_ready_reg(cmd_ready_reg), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
  .rsp_valid_reg(rsp_valid_reg), .ad_out_reg(ad_out_reg), .ad_oe_reg(ad_oe_reg), .addr_hi_reg(addr_hi_reg),
  .cs_n_reg(cs_n_reg), .ale_reg(ale_reg), .rd_n_reg(rd_n_reg), .wr_n_reg(wr_n_reg),
  .clock_monitor_out(clock_monitor_out));

// ===== verification/mhb_periph_model.sv
// Purpose: peripheral on the multiplexed bus
// Assumes: address latched on the falling latch pulse
// Notes:   released bus floats high through pull-ups
`timescale 1ns/1ps
module mhb_periph_model (
  // bus from the master
  input  wire [7:0] ad_out_reg,
  input  wire       ad_oe_reg,
  input  wire       ale_reg,
  input  wire       cs_n_reg,
  input  wire       rd_n_reg,
  input  wire       wr_n_reg,
  // bus to the master
  output wire [7:0] ad_in
);
  reg     [7:0] mem [0:255];
  reg     [7:0] lat;
  integer       i;
  initial begin
    lat = 8'h00;
    for (i = 0; i < 256; i = i + 1) mem[i] = ~i[7:0];
  end
  always @(negedge ale_reg) lat = ad_in;
  always @(posedge wr_n_reg) if (!cs_n_reg) mem[lat] = ad_in;
  assign ad_in = ad_oe_reg ? ad_out_reg : (!cs_n_reg && !rd_n_reg) ? mem[lat] : 8'hFF;
endmodule

// ===== verification/mhb_bus_master_test.sv
// Purpose: self-checking bench for the host bus master
// Assumes: HALF_CYC of 2, a bus half period of two mclk cycles
// Notes:   peripheral memory starts as the inverted address; reads return the stored byte
`timescale 1ns/1ps
module mhb_bus_master_test;
  localparam H = 2;
  reg         mclk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, wait_extend_in = 1'b1, irq_lvl = 1'b1;
  reg  [2:0]  cmd_op = 3'h0;
  reg  [15:0] cmd_addr = 16'h0000;
  reg  [7:0]  cmd_data = 8'h00;
  wire        cmd_ready_reg, rsp_valid_reg, ad_oe_reg, cs_n_reg, ale_reg, rd_n_reg, wr_n_reg, clock_monitor_out;
  wire        f_out, f_oe, q_out, q_oe;
  wire [7:0]  rsp_data_reg, ad_in, ad_out_reg, addr_hi_reg;
  integer     miscompares = 0, n_compared = 0, ww = 0, aw = 0, rw = 0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (!wr_n_reg) ww <= ww + 1;
    if (ale_reg) aw <= aw + 1;
    if (!rd_n_reg) rw <= rw + 1;
  end
  mhb_bus_master #(.HALF_CYC(H)) dut (.mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_ready_reg(cmd_ready_reg), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .rsp_valid_reg(rsp_valid_reg), .rsp_data_reg(rsp_data_reg), .ad_in(ad_in), .ad_out_reg(ad_out_reg),
    .ad_oe_reg(ad_oe_reg), .addr_hi_reg(addr_hi_reg), .cs_n_reg(cs_n_reg), .ale_reg(ale_reg),
    .rd_n_reg(rd_n_reg), .wr_n_reg(wr_n_reg), .wait_extend_in(wait_extend_in),
    .aux_pin_first_in(f_oe ? f_out : 1'b1), .aux_pin_first_out_reg(f_out), .aux_pin_first_oe_reg(f_oe),
    .aux_irq_pin_in(q_oe ? q_out : irq_lvl), .aux_irq_pin_out_reg(q_out), .aux_irq_pin_oe_reg(q_oe),
    .clock_monitor_out(clock_monitor_out));
  mhb_periph_model u_per (.ad_out_reg(ad_out_reg), .ad_oe_reg(ad_oe_reg), .ale_reg(ale_reg),
    .cs_n_reg(cs_n_reg), .rd_n_reg(rd_n_reg), .wr_n_reg(wr_n_reg), .ad_in(ad_in));
  task cmp(input string what, input [15:0] exp, input [15:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task idle;
    integer n;
    n = 0;
    while (cmd_ready_reg !== 1'b1 && n < 400) begin
      @(posedge mclk) #1;
      n = n + 1;
    end
    if (n >= 400) cmp("cmd ready timeout", 16'h0001, {15'h0000, cmd_ready_reg});
  endtask
  task send(input [2:0] op, input [15:0] a, input [7:0] d);
    @(posedge mclk) #1;
    idle;
    {cmd_op, cmd_addr, cmd_data, cmd_valid} = {op, a, d, 1'b1};
    @(posedge mclk) #1 cmd_valid = 1'b0;
  endtask
  task ask(input [2:0] op, input [15:0] a, input [7:0] exp, input string what);
    integer n;
    n = 0;
    send(op, a, 8'h00);
    while (rsp_valid_reg !== 1'b1 && n < 400) begin
      @(posedge mclk) #1;
      n = n + 1;
    end
    if (n >= 400) cmp("rsp valid timeout", 16'h0001, {15'h0000, rsp_valid_reg});
    cmp(what, {8'h00, exp}, {8'h00, rsp_data_reg});
  endtask
  task t_bus;
    {ww, aw} = 0;
    send(3'h3, 16'h5A3C, 8'hC3);
    idle;
    cmp("addr_hi ext", 16'h005A, addr_hi_reg);
    cmp("stored C3", 16'h00C3, u_per.mem[8'h3C]);
    cmp("write width", 2 * H, ww);
    cmp("ale width", 2 * H, aw);
    send(3'h2, 16'h1281, 8'h7E);
    idle;
    cmp("addr_hi plain", 16'h005A, addr_hi_reg);
    cmp("stored 7E", 16'h007E, u_per.mem[8'h81]);
    ask(3'h1, 16'h77BD, 8'h42, "read ext");
    rw = 0;
    ask(3'h0, 16'h99C3, 8'h3C, "read plain");
    cmp("addr_hi read", 16'h0077, addr_hi_reg);
    cmp("read width", 2 * H, rw);
    $display("test bus done");
  endtask
  task t_stretch;
    {ww, aw, wait_extend_in} = 0;
    send(3'h2, 16'h0010, 8'hA5);
    idle;
    cmp("ale stretched", 4 * H, aw);
    cmp("write stretched", 12 * H, ww);
    rw = 0;
    ask(3'h0, 16'h0010, 8'hA5, "read stretched data");
    cmp("read stretched", 10 * H, rw);
    wait_extend_in = 1'b1;
    $display("test stretch done");
  endtask
  task t_aux;
    irq_lvl = 1'b0;
    send(3'h4, 16'h0003, 8'h02);
    repeat (3) @(posedge mclk) #1;
    cmp("aux pins drive", 16'h000E, {q_oe, q_out, f_oe, f_out});
    ask(3'h5, 16'h0000, 8'h02, "aux read driven");
    send(3'h4, 16'h0001, 8'h01);
    repeat (3) @(posedge mclk) #1;
    cmp("aux first drive", 16'h0003, {f_oe, f_out});
    cmp("aux irq input", 16'h0000, q_oe);
    ask(3'h5, 16'h0000, 8'h01, "aux read set");
    irq_lvl = 1'b1;
    $display("test aux done");
  endtask
  task t_irq;
    send(3'h7, 16'h0000, 8'h00);
    repeat (20) @(posedge mclk) #1;
    cmp("stall low", 16'h0000, cmd_ready_reg);
    irq_lvl = 1'b0;
    ask(3'h0, 16'h0042, 8'hBD, "irq read");
    send(3'h6, 16'h0000, 8'h00);
    repeat (20) @(posedge mclk) #1;
    cmp("stall high", 16'h0000, cmd_ready_reg);
    irq_lvl = 1'b1;
    idle;
    cmp("resume high", 16'h0001, cmd_ready_reg);
    $display("test irq done");
  endtask
  task t_reset;
    @(posedge mclk) #1 reset_n = 1'b0;
    repeat (2) @(posedge mclk) #1;
    cmp("reset addr_hi", 16'h0000, addr_hi_reg);
    cmp("reset strobes", 16'h002D, {f_oe, cs_n_reg, ale_reg, rd_n_reg, wr_n_reg, ad_oe_reg, cmd_ready_reg});
    reset_n = 1'b1;
    repeat (3) @(posedge mclk);
    ask(3'h1, 16'h3355, 8'hAA, "read after reset");
    cmp("addr_hi after reset", 16'h0033, addr_hi_reg);
    $display("test reset done");
  endtask
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge mclk);
    t_bus;
    t_stretch;
    t_aux;
    t_irq;
    t_reset;
    close_out;
  end
  initial begin
    #100000;
    miscompares = miscompares + 1;
    close_out;
  end
endmodule
